// >>> hdl/clock_power_control.sv
// sample-clock path and power-state control of the converter
// assumes register port and loose controls come from logic on clk_sys,
// and that sync, power-down and reference-select pins are asynchronous
//
// Contract
// - divide input clock by one through eight
// - realign mode bits: every strobe or once
// - valid strobe returns divider to initial count
// - stabilizer sets falling edge at half period
// - stabilizer inactive below twenty megahertz input
// - three-bit field selects power-saving mode
// - pin or register enters power-down; pin releases
// - output drivers high impedance while powered down
// - power-down disables reference, buffer, bias, clock
// - standby keeps reference, register-only, faster wake
// - wake-up time scales with time powered down
// - reference-select low means internal reference
// - sampling on rising edge of sample clock
// - undriven alignment strobe reads inactive low
`timescale 1ns/100ps
`default_nettype none
module clock_power_control
    import clock_power_pkg::*;
#(
    parameter int PD_TIME_W = 16,
    parameter int WAKE_SHIFT = 2,
    parameter int STANDBY_SHIFT = 4
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    output logic [REG_DATA_W-1:0] reg_rdata,
    input wire logic sync_pin,
    input wire logic powerdown_pin,
    input wire logic sense_pin_high,
    input wire logic [DIV_RATIO_W-1:0] divide_ratio_m1,
    input wire logic duty_cycle_stabilizer,
    output logic sample_clock,
    output logic sample_strobe,
    output logic dcs_locked,
    output logic converter_ready,
    output logic output_drive_oe_n,
    output logic reference_enable,
    output logic internal_ref_select,
    output logic ref_buffer_enable,
    output logic bias_enable,
    output logic clock_enable,
    output logic [2:0] power_level
);
    logic [REG_DATA_W-1:0] power_mode_select;
    logic [REG_DATA_W-1:0] divider_realign_control;
    logic armed;
    logic sync_meta, sync_sync, sync_prev;
    logic pd_meta, pd_sync;
    logic sense_meta, sense_sync;
    logic realign_pulse;
    power_state_type state, next_state;
    logic [PD_TIME_W-1:0] pd_time;
    logic [PD_TIME_W-1:0] wake_cnt;
    logic [DCS_CNT_W-1:0] relock_cnt;
    logic [DIV_RATIO_W-1:0] ratio_q;
    logic down_req, stby_req;
    logic wr_realign, sync_rise, realign_ok;

    // register writes
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_mode_select <= POWER_MODE_RESET;
            divider_realign_control <= REALIGN_RESET;
        end
        else if (reg_write)
        begin
            if (reg_addr == ADDR_POWER_MODE)
                power_mode_select <= reg_wdata;
            if (reg_addr == ADDR_REALIGN)
                divider_realign_control <= reg_wdata;
        end
    end

    // register reads; unmapped addresses read zero, armed flag in bit 2
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_read)
        begin
            if (reg_addr == ADDR_POWER_MODE)
                reg_rdata <= power_mode_select;
            else if (reg_addr == ADDR_REALIGN)
            begin
                reg_rdata <= divider_realign_control;
                reg_rdata[REALIGN_ARMED_BIT] <= armed;
            end
            else
                reg_rdata <= '0;
        end
    end

    // pin synchronisers; sync resets low as its pull-down reads
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_meta <= 1'b0;
            sync_sync <= 1'b0;
            sync_prev <= 1'b0;
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
            sense_meta <= 1'b0;
            sense_sync <= 1'b0;
        end
        else
        begin
            sync_meta <= sync_pin;
            sync_sync <= sync_meta;
            sync_prev <= sync_sync;
            pd_meta <= powerdown_pin;
            pd_sync <= pd_meta;
            sense_meta <= sense_pin_high;
            sense_sync <= sense_meta;
        end
    end

    assign wr_realign = reg_write && (reg_addr == ADDR_REALIGN);
    assign sync_rise = sync_sync && !sync_prev;
    assign realign_ok = divider_realign_control[REALIGN_EN_BIT]
        && (!divider_realign_control[REALIGN_ONCE_BIT] || armed);

    // one-shot arming: a write re-arms and wins over a same-cycle strobe
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            armed <= 1'b0;
        else if (wr_realign)
            armed <= 1'b1;
        else if (sync_rise && realign_ok)
            armed <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            realign_pulse <= 1'b0;
        else
            realign_pulse <= sync_rise && realign_ok;
    end

    // power state
    assign down_req = pd_sync || (power_mode_select[PM_MSB:PM_LSB] == PM_POWERDOWN);
    assign stby_req = power_mode_select[PM_MSB:PM_LSB] == PM_STANDBY;

    always_comb
    begin
        next_state = state;
        case (state)
            PS_RUN, PS_WAKE:
            begin
                if (down_req)
                    next_state = PS_DOWN;
                else if (stby_req)
                    next_state = PS_STANDBY;
                else if (state == PS_WAKE && wake_cnt == '0)
                    next_state = PS_RUN;
            end
            PS_DOWN, PS_STANDBY:
            begin
                if (down_req)
                    next_state = PS_DOWN;
                else if (stby_req)
                    next_state = PS_STANDBY;
                else
                    next_state = PS_WAKE;
            end
            default:
                next_state = PS_DOWN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state <= PS_RUN;
        else
            state <= next_state;
    end

    // time spent down sets the wake delay
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pd_time <= '0;
            wake_cnt <= '0;
        end
        else
        begin
            if (state == PS_RUN)
                pd_time <= '0;
            else if ((state == PS_DOWN || state == PS_STANDBY) && pd_time != '1)
                pd_time <= pd_time + 1'b1;
            if (next_state == PS_WAKE && state != PS_WAKE)
                wake_cnt <= (state == PS_STANDBY) ? (pd_time >> STANDBY_SHIFT) : (pd_time >> WAKE_SHIFT);
            else if (state == PS_WAKE && wake_cnt != '0)
                wake_cnt <= wake_cnt - 1'b1;
        end
    end

    // power outputs follow the next state; power_level follows the mode field and internal_ref_select the sense pin
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converter_ready <= 1'b0;
            output_drive_oe_n <= 1'b1;
            reference_enable <= 1'b0;
            internal_ref_select <= 1'b1;
            ref_buffer_enable <= 1'b0;
            bias_enable <= 1'b0;
            clock_enable <= 1'b0;
            power_level <= PM_NORMAL;
        end
        else
        begin
            converter_ready <= next_state == PS_RUN;
            output_drive_oe_n <= next_state == PS_DOWN || next_state == PS_STANDBY;
            reference_enable <= next_state != PS_DOWN && !sense_sync;
            internal_ref_select <= !sense_sync;
            ref_buffer_enable <= next_state == PS_RUN || next_state == PS_WAKE;
            bias_enable <= next_state == PS_RUN || next_state == PS_WAKE;
            clock_enable <= next_state == PS_RUN || next_state == PS_WAKE;
            power_level <= power_mode_select[PM_MSB:PM_LSB];
        end
    end

    // stabilizer lock: reloads on ratio change or stop
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ratio_q <= '0;
            relock_cnt <= DCS_CNT_W'(DCS_RELOCK_CYCLES);
            dcs_locked <= 1'b0;
        end
        else
        begin
            ratio_q <= divide_ratio_m1;
            if (!duty_cycle_stabilizer || !clock_enable || ratio_q != divide_ratio_m1
                || CLK_SYS_HZ < DCS_MIN_HZ)
                relock_cnt <= DCS_CNT_W'(DCS_RELOCK_CYCLES);
            else if (relock_cnt != '0)
                relock_cnt <= relock_cnt - 1'b1;
            dcs_locked <= duty_cycle_stabilizer && clock_enable && relock_cnt == '0;
        end
    end

    sample_clock_divider #(
        .RW(DIV_RATIO_W)
    ) u_divider (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(clock_enable),
        .ratio_m1(divide_ratio_m1),
        .realign(realign_pulse),
        .dcs_on(duty_cycle_stabilizer && (CLK_SYS_HZ >= DCS_MIN_HZ)),
        .sample_pulse(sample_strobe),
        .clk_level(sample_clock)
    );

    sequence pin_held;
        powerdown_pin [*4];
    endsequence
    sequence wake_at_three;
        state == PS_WAKE && wake_cnt == PD_TIME_W'(3) && !down_req && !stby_req;
    endsequence

    AST_PIN_DOWN: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pin_held |=> (output_drive_oe_n && !converter_ready))
        else $error("power-down pin did not shut the outputs");

    AST_PD_SHUT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state == PS_DOWN) |-> (!reference_enable && !ref_buffer_enable && !bias_enable && !clock_enable))
        else $error("power-down left a block enabled");

    AST_STBY_REF: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state == PS_STANDBY && $past(!sense_sync)) |-> (reference_enable && !bias_enable && output_drive_oe_n))
        else $error("standby did not keep reference only");

    AST_WAKE_LEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wake_at_three ##1 (!down_req && !stby_req) [*3] |=> converter_ready && !$past(converter_ready))
        else $error("wake-up length wrong");

    AST_REALIGN_ONCE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (sync_rise && realign_ok && divider_realign_control[REALIGN_ONCE_BIT] && !wr_realign)
        |=> (!armed ##1 (!realign_pulse || armed)))
        else $error("one-shot realign did not disarm");

    AST_SYNC_ONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        realign_pulse |=> !realign_pulse)
        else $error("one strobe caused two realignments");

    AST_REF_SEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sense_pin_high [*3] |=> !internal_ref_select)
        else $error("reference select ignored sense level");
endmodule
`default_nettype wire

// >>> hdl/clock_power_pkg.sv
// constants for the sample-clock divider and power-state control
// assumes one system clock at 40 MHz and an internal register port
package clock_power_pkg;
    localparam int REG_ADDR_W = 9;
    localparam int REG_DATA_W = 8;
    localparam logic [REG_ADDR_W-1:0] ADDR_POWER_MODE = 9'h100;
    localparam logic [REG_ADDR_W-1:0] ADDR_REALIGN = 9'h109;
    localparam logic [REG_DATA_W-1:0] POWER_MODE_RESET = 8'h00;
    localparam logic [REG_DATA_W-1:0] REALIGN_RESET = 8'h00;
    // power_mode_select field, bits 2:0
    localparam int PM_MSB = 2;
    localparam int PM_LSB = 0;
    localparam logic [2:0] PM_NORMAL = 3'h0;
    localparam logic [2:0] PM_POWERDOWN = 3'h1;
    localparam logic [2:0] PM_STANDBY = 3'h2;
    // divider_realign_control fields
    localparam int REALIGN_EN_BIT = 0;
    localparam int REALIGN_ONCE_BIT = 1;
    localparam int REALIGN_ARMED_BIT = 2;
    // divider
    localparam int DIV_RATIO_W = 3;
    // timing
    localparam longint CLK_SYS_HZ = 40_000_000;
    localparam longint DCS_MIN_HZ = 20_000_000;
    localparam longint DCS_RELOCK_NS = 5000;
    localparam int DCS_RELOCK_CYCLES = int'(DCS_RELOCK_NS * CLK_SYS_HZ / 1_000_000_000);
    localparam int DCS_CNT_W = 8;
    typedef enum logic [1:0] {PS_RUN, PS_STANDBY, PS_DOWN, PS_WAKE} power_state_type;
endpackage

// >>> hdl/sample_clock_divider.sv
// integer divider of the input clock, with realignment and duty shaping
// assumes realign is a single-cycle pulse on clk_sys
`timescale 1ns/100ps
`default_nettype none
module sample_clock_divider
    import clock_power_pkg::*;
#(
    parameter int RW = DIV_RATIO_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [RW-1:0] ratio_m1,
    input wire logic realign,
    input wire logic dcs_on,
    output logic sample_pulse,
    output logic clk_level
);
    logic [RW-1:0] count;
    logic [RW-1:0] next_count;
    logic [RW:0] high_len;

    always_comb
    begin
        if (!run || realign)
            next_count = '0;
        else if (count == ratio_m1)
            next_count = '0;
        else
            next_count = count + 1'b1;
        high_len = ({1'b0, ratio_m1} + 2'd2) >> 1;
    end

    // count 0 is the initial state; realign returns to it
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else
            count <= next_count;
    end

    // rising edge of the divided clock marks the sample
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_pulse <= 1'b0;
            clk_level <= 1'b0;
        end
        else
        begin
            sample_pulse <= run && (next_count == '0);
            // stabilizer places the falling edge at half period
            clk_level <= run && (dcs_on ? ({1'b0, next_count} < high_len) : (next_count == '0));
        end
    end

    logic [RW-1:0] gap;
    logic clean;
    logic [RW-1:0] ratio_q;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap <= '0;
            clean <= 1'b0;
            ratio_q <= '0;
        end
        else
        begin
            ratio_q <= ratio_m1;
            gap <= sample_pulse ? '0 : gap + 1'b1;
            if (realign || !run || ratio_q != ratio_m1)
                clean <= 1'b0;
            else if (sample_pulse)
                clean <= 1'b1;
        end
    end

    AST_DIV_PERIOD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (sample_pulse && clean) |-> (gap == ratio_q))
        else $error("divided period differs from selected ratio");

    AST_REALIGN_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (realign && run) |=> (sample_pulse && count == '0))
        else $error("realign did not restart the divider");
endmodule
`default_nettype wire

// >>> testbench/clock_power_control_tb.sv
// self-checking bench for the sample-clock and power-state controller
// assumes the far-side model drives the asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module clock_power_control_tb;
    import clock_power_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n;
    logic reg_write;
    logic reg_read;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [REG_DATA_W-1:0] reg_wdata;
    logic [REG_DATA_W-1:0] reg_rdata;
    logic [DIV_RATIO_W-1:0] divide_ratio_m1;
    logic duty_cycle_stabilizer;
    logic sync_pin, powerdown_pin, sense_pin_high, sample_clock, sample_strobe, dcs_locked, converter_ready;
    logic output_drive_oe_n, reference_enable, internal_ref_select, ref_buffer_enable, bias_enable, clock_enable;
    logic [2:0] power_level;
    logic [7:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    int k, h, w1, w2, w3;
    far_side_model u_far (.clk_sys(clk_sys), .sync_pin(sync_pin), .powerdown_pin(powerdown_pin),
        .sense_pin_high(sense_pin_high));
    clock_power_control #(.PD_TIME_W(8)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sync_pin(sync_pin), .powerdown_pin(powerdown_pin), .sense_pin_high(sense_pin_high),
        .divide_ratio_m1(divide_ratio_m1), .duty_cycle_stabilizer(duty_cycle_stabilizer),
        .sample_clock(sample_clock), .sample_strobe(sample_strobe), .dcs_locked(dcs_locked),
        .converter_ready(converter_ready), .output_drive_oe_n(output_drive_oe_n),
        .reference_enable(reference_enable), .internal_ref_select(internal_ref_select),
        .ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable), .clock_enable(clock_enable),
        .power_level(power_level));
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic give_up(input string what);
        n_fail++;
        $display("Error at %0t: timeout %s", $time, what);
        summarize();
    endtask
    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_write = 1'b0;
    endtask
    task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
    // edges up to the next strobe, and high cycles of sample_clock in between
    task automatic wait_strobe(output int n, output int hi);
        n = 0;
        hi = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
            if (sample_strobe !== 1'b1 && sample_clock === 1'b1)
                hi++;
        end
        while (sample_strobe !== 1'b1 && n < 64);
        if (n >= 64)
            give_up("strobe");
    endtask
    task automatic wake(output int n);
        n = 0;
        while (converter_ready !== 1'b1 && n < 1000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 1000)
            give_up("wake");
    endtask
    task automatic t_regs;
        reg_rd(ADDR_POWER_MODE, rd);
        check(rd, POWER_MODE_RESET, "power mode reset");
        reg_rd(ADDR_REALIGN, rd);
        check(rd, REALIGN_RESET, "realign reset");
        reg_wr(9'h1FF, 8'hFF);
        reg_rd(9'h1FF, rd);
        check(rd, 8'h00, "unmapped read");
        reg_wr(ADDR_REALIGN, 8'h03);
        reg_rd(ADDR_REALIGN, rd);
        check(rd, 8'h07, "armed flag");
    endtask
    task automatic t_ratio;
        for (int d = 0; d < 2; d++)
        begin
            for (int r = 0; r < 8; r++)
            begin
                @(negedge clk_sys);
                duty_cycle_stabilizer = d[0];
                divide_ratio_m1 = r[2:0];
                wait_strobe(k, h);
                check(sample_clock, 1'b1, "rise at strobe");
                wait_strobe(k, h);
                check(k[7:0], r[7:0] + 8'h01, "period");
                check(h[7:0] + 8'h01, d ? (r[7:0] + 8'h02) >> 1 : 8'h01, "high time");
            end
        end
    endtask
    task automatic t_lock;
        @(negedge clk_sys);
        divide_ratio_m1 = 3'h3;
        repeat (3) @(negedge clk_sys);
        check(dcs_locked, 1'b0, "relocking");
        u_far.relock_wait();
        repeat (4) @(negedge clk_sys);
        check(dcs_locked, 1'b1, "locked");
    endtask
    task automatic do_sync(input int exp);
        wait_strobe(k, h);
        fork
            u_far.strobe(2);
            wait_strobe(k, h);
        join
        check(k[7:0], exp[7:0], "realign delay");
    endtask
    task automatic t_sync;
        logic [7:0] mode [3] = '{8'h01, 8'h00, 8'h03};
        int first [3] = '{4, 8, 4};
        int second [3] = '{4, 8, 8};
        @(negedge clk_sys);
        divide_ratio_m1 = 3'h7;
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(ADDR_REALIGN, mode[i]);
            do_sync(first[i]);
            do_sync(second[i]);
        end
        reg_rd(ADDR_REALIGN, rd);
        check(rd, 8'h03, "armed consumed");
    endtask
    task automatic pd_cycle(input int cycles, output int n);
        u_far.set_pd(1'b1);
        repeat (4) @(negedge clk_sys);
        check(output_drive_oe_n, 1'b1, "hi-z");
        check({reference_enable, ref_buffer_enable, bias_enable, clock_enable}, 8'h00, "shut");
        check(converter_ready, 1'b0, "down");
        repeat (cycles) @(negedge clk_sys);
        check(sample_strobe, 1'b0, "clock stopped");
        u_far.set_pd(1'b0);
        wake(n);
    endtask
    task automatic t_power;
        pd_cycle(40, w1);
        pd_cycle(160, w2);
        check(w2 > w1, 1'b1, "wake scales");
        reg_wr(ADDR_POWER_MODE, {5'h00, PM_STANDBY});
        repeat (164) @(negedge clk_sys);
        check({output_drive_oe_n, reference_enable, clock_enable}, 8'h06, "standby");
        reg_wr(ADDR_POWER_MODE, {5'h00, PM_NORMAL});
        wake(w3);
        check(w3 < w2, 1'b1, "standby faster");
        for (int m = 1; m < 8; m++)
        begin
            reg_wr(ADDR_POWER_MODE, m[7:0]);
            repeat (4) @(negedge clk_sys);
            check(power_level, m[2:0], "level");
            check(output_drive_oe_n, m == 1 || m == 2, "mode hi-z");
        end
        reg_wr(ADDR_POWER_MODE, {5'h00, PM_NORMAL});
        wake(w3);
    endtask
    task automatic t_sense;
        u_far.set_sense(1'b1);
        repeat (4) @(negedge clk_sys);
        check({internal_ref_select, reference_enable}, 8'h00, "external ref");
        u_far.set_sense(1'b0);
        repeat (4) @(negedge clk_sys);
        check({internal_ref_select, reference_enable}, 8'h03, "internal ref");
    endtask
    initial
    begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        divide_ratio_m1 = 3'h0;
        duty_cycle_stabilizer = 1'b1;
        repeat (10) @(negedge clk_sys);
        check({output_drive_oe_n, internal_ref_select, converter_ready}, 8'h06, "in reset");
        reset_n = 1'b1;
        t_regs();
        t_ratio();
        t_lock();
        t_sync();
        t_power();
        t_sense();
        summarize();
    end
endmodule
`default_nettype wire

// >>> testbench/far_side_model.sv
// far-side model: alignment strobe source, power-down pin, reference-select pin
// assumes clk_sys from the bench; pins change only at falling edges
`timescale 1ns/100ps
`default_nettype none
module far_side_model
    import clock_power_pkg::*;
(
    input wire logic clk_sys,
    output logic sync_pin,
    output logic powerdown_pin,
    output logic sense_pin_high
);
    initial
    begin
        sync_pin = 1'b0;
        powerdown_pin = 1'b0;
        sense_pin_high = 1'b0;
    end
    // strobe held high a few cycles, then low long enough before the next rise
    task automatic strobe(input int high_cycles);
        @(negedge clk_sys);
        sync_pin = 1'b1;
        repeat (high_cycles) @(negedge clk_sys);
        sync_pin = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic set_pd(input logic v);
        @(negedge clk_sys);
        powerdown_pin = v;
    endtask
    // the select pin is always driven to a defined level
    task automatic set_sense(input logic v);
        @(negedge clk_sys);
        sense_pin_high = v;
    endtask
    // bench waits out the stabilizer relock time after a rate change
    task automatic relock_wait;
        repeat (DCS_RELOCK_CYCLES) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire
